// File: rtl/pss_pkg.sv
// constants for the phy summary status and interrupt control block
// assumes an apb slave with 32-bit data; register words hold 16 bits
package pss_pkg;

  // bus widths
  localparam int unsigned PSS_AW = 10;
  localparam int unsigned PSS_DW = 32;
  localparam int unsigned PSS_RW = 16;

  // register indices; byte address is four times the index
  localparam logic [7:0] PSS_IDX_BASIC   = 8'h01;
  localparam logic [7:0] PSS_IDX_SUMMARY = 8'h10;
  localparam logic [7:0] PSS_IDX_CTRL    = 8'h11;
  localparam logic [7:0] PSS_IDX_EVENT   = 8'h12;

  // summary status field positions
  localparam int unsigned PSS_SUM_LINK   = 0;
  localparam int unsigned PSS_SUM_SPEED  = 1;
  localparam int unsigned PSS_SUM_DUPLEX = 2;
  localparam int unsigned PSS_SUM_LOOP   = 3;
  localparam int unsigned PSS_SUM_ANC    = 4;
  localparam int unsigned PSS_SUM_JAB    = 5;
  localparam int unsigned PSS_SUM_RFAULT = 6;
  localparam int unsigned PSS_SUM_IRQ    = 7;

  // interrupt control field positions
  localparam int unsigned PSS_CTL_OE     = 0;
  localparam int unsigned PSS_CTL_EVT_IRQ_EN = 1;
  localparam int unsigned PSS_CTL_TEST   = 2;
  localparam int unsigned PSS_CTL_W      = 3;

  // basic status field positions
  localparam int unsigned PSS_BAS_JAB    = 1;
  localparam int unsigned PSS_BAS_LINK   = 2;
  localparam int unsigned PSS_BAS_RFAULT = 4;
  localparam int unsigned PSS_BAS_ANC    = 5;

  // event status and enable layout
  localparam int unsigned PSS_EVT_N      = 8;
  localparam int unsigned PSS_EVT_LSB    = 8;

  // reset values
  localparam logic [2:0]  PSS_CTRL_RST   = 3'h0;
  localparam logic [7:0]  PSS_EVT_RST    = 8'h00;
  localparam logic [15:0] PSS_WORD_RST   = 16'h0000;
  localparam logic        PSS_PIN_IDLE   = 1'b1;

endpackage

// File: rtl/pss_sync3.sv
// three-stage synchroniser for one pin level
// assumes an asynchronous pin; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pss_sync3
  import pss_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and result
  input  wire logic pin_raw,
  output logic      pin_level
);

  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= PSS_PIN_IDLE;
      s2_q  <= PSS_PIN_IDLE;
      s3_q  <= PSS_PIN_IDLE;
      lvl_q <= PSS_PIN_IDLE;
    end else begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pin_level = lvl_q;

endmodule
`default_nettype wire

// File: rtl/pss_top.sv
// phy summary status, interrupt control and event status registers, apb slave
// assumes status levels and event pulses come from logic on pclk; the shared
// pin is asynchronous and is resolved outside from the output enable
`timescale 1ns/1ps
`default_nettype none
module pss_top
  import pss_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [PSS_AW-1:0] paddr,
  input  wire logic [PSS_DW-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [PSS_DW-1:0]      prdata,
  output logic                   pslverr,
  // phy status levels
  input  wire logic              link_up,
  input  wire logic              speed_10,
  input  wire logic              full_duplex,
  input  wire logic              loopback_on,
  input  wire logic              an_complete,
  input  wire logic              jabber_seen,
  input  wire logic              remote_fault_seen,
  // phy event pulses
  input  wire logic [7:0]        evt_pulse,
  // shared power-down / interrupt pin, active low
  input  wire logic              irq_pin_n_i,
  output logic                   irq_pin_n_o,
  output logic                   irq_pin_n_oe,
  // power-down request from the pin
  output logic                   powerdown_req
);

  function automatic logic hit(input logic [PSS_AW-1:0] a, input logic [7:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic mapped(input logic [PSS_AW-1:0] a);
    return hit(a, PSS_IDX_BASIC) || hit(a, PSS_IDX_SUMMARY) ||
           hit(a, PSS_IDX_CTRL) || hit(a, PSS_IDX_EVENT);
  endfunction

  // bus phases
  logic setup_ph, acc_ph, rd_acc, wr_acc;
  assign setup_ph = psel && !penable;
  assign acc_ph   = psel && penable;
  assign rd_acc   = acc_ph && !pwrite;
  assign wr_acc   = acc_ph && pwrite;

  // state
  logic [PSS_CTL_W-1:0] ctrl_q, ctrl_d;
  logic [PSS_EVT_N-1:0] evt_en_q, evt_en_d;
  logic [PSS_EVT_N-1:0] flag_q, flag_d;
  logic                 rf_q, rf_d;
  logic                 irq_q, irq_d;
  logic [PSS_RW-1:0]    rdata_q, rdata_d;
  logic                 err_q, err_d;
  logic [PSS_EVT_N-1:0] evt_clr;

  // register words as they read now
  logic [PSS_RW-1:0] summary_w, ctrl_w, event_w, basic_w;

  always_comb begin
    summary_w = PSS_WORD_RST;
    summary_w[PSS_SUM_LINK]   = link_up;
    summary_w[PSS_SUM_SPEED]  = speed_10;
    summary_w[PSS_SUM_DUPLEX] = full_duplex;
    summary_w[PSS_SUM_LOOP]   = loopback_on;
    summary_w[PSS_SUM_ANC]    = an_complete;
    summary_w[PSS_SUM_JAB]    = jabber_seen;
    summary_w[PSS_SUM_RFAULT] = rf_q;
    summary_w[PSS_SUM_IRQ]    = irq_q;
  end

  always_comb begin
    ctrl_w                = PSS_WORD_RST;
    ctrl_w[PSS_CTL_W-1:0] = ctrl_q;
    event_w               = {flag_q, evt_en_q};
    basic_w               = PSS_WORD_RST;
    basic_w[PSS_BAS_JAB]    = jabber_seen;
    basic_w[PSS_BAS_LINK]   = link_up;
    basic_w[PSS_BAS_RFAULT] = rf_q;
    basic_w[PSS_BAS_ANC]    = an_complete;
  end

  // read data is captured in the setup phase so prdata comes from a flop;
  // read side effects happen at the access edge; event flags clear only captured bits, the remote fault latch clears regardless of what was captured
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup_ph) begin
      err_d   = !mapped(paddr);
      rdata_d = PSS_WORD_RST;
      if (!pwrite) begin
        if (hit(paddr, PSS_IDX_SUMMARY)) begin
          rdata_d = summary_w;
        end else if (hit(paddr, PSS_IDX_CTRL)) begin
          rdata_d = ctrl_w;
        end else if (hit(paddr, PSS_IDX_EVENT)) begin
          rdata_d = event_w;
        end else if (hit(paddr, PSS_IDX_BASIC)) begin
          rdata_d = basic_w;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= PSS_WORD_RST;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = {{(PSS_DW-PSS_RW){1'b0}}, rdata_q};
  assign pslverr = acc_ph && err_q;

  // control and enable registers
  always_comb begin
    ctrl_d   = ctrl_q;
    evt_en_d = evt_en_q;
    if (wr_acc && pstrb[0]) begin
      if (hit(paddr, PSS_IDX_CTRL)) begin
        ctrl_d = pwdata[PSS_CTL_W-1:0];
      end
      if (hit(paddr, PSS_IDX_EVENT)) begin
        evt_en_d = pwdata[PSS_EVT_N-1:0];
      end
    end
  end

  // latched remote fault, set wins over the read clear
  always_comb begin
    rf_d = remote_fault_seen || (rf_q && !(rd_acc && hit(paddr, PSS_IDX_BASIC)));
  end

  // clear only what the read returned
  assign evt_clr = (rd_acc && hit(paddr, PSS_IDX_EVENT)) ?
                   rdata_q[PSS_EVT_LSB +: PSS_EVT_N] : PSS_EVT_RST;

  // flags set even when the event is masked
  genvar gi;
  generate
    for (gi = 0; gi < PSS_EVT_N; gi++) begin : g_flag
      always_comb begin
        flag_d[gi] = evt_pulse[gi] || (flag_q[gi] && !evt_clr[gi]);
      end
    end
  endgenerate

  // test forces, else enabled and pending events with global enable
  always_comb begin
    irq_d = ctrl_q[PSS_CTL_TEST] ||
            (ctrl_q[PSS_CTL_EVT_IRQ_EN] && |(flag_q & evt_en_q));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= PSS_CTRL_RST;
      evt_en_q <= PSS_EVT_RST;
      flag_q   <= PSS_EVT_RST;
      rf_q     <= 1'b0;
      irq_q    <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      evt_en_q <= evt_en_d;
      flag_q   <= flag_d;
      rf_q     <= rf_d;
      irq_q    <= irq_d;
    end
  end

  // shared pin: power-down input is only meaningful while not driving
  logic pin_level;

  pss_sync3 u_pin_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_raw   (irq_pin_n_i),
    .pin_level (pin_level)
  );

  // pin role from control bit 0
  assign irq_pin_n_oe  = ctrl_q[PSS_CTL_OE];
  assign irq_pin_n_o   = !irq_q;
  assign powerdown_req = !ctrl_q[PSS_CTL_OE] && !pin_level;

  // checks

  logic rd_basic_acc;
  assign rd_basic_acc = rd_acc && hit(paddr, PSS_IDX_BASIC);

  sequence s_sum_setup;
    setup_ph && !pwrite && hit(paddr, PSS_IDX_SUMMARY);
  endsequence

  sequence s_evt_setup;
    setup_ph && !pwrite && hit(paddr, PSS_IDX_EVENT);
  endsequence

  sequence s_quiet_access;
    acc_ph && (evt_pulse == PSS_EVT_RST) && (flag_q == rdata_q[PSS_EVT_LSB +: PSS_EVT_N]);
  endsequence

  sequence s_ctrl_write;
    wr_acc && pstrb[0] && hit(paddr, PSS_IDX_CTRL);
  endsequence

  sequence s_evt_write;
    wr_acc && pstrb[0] && hit(paddr, PSS_IDX_EVENT);
  endsequence

  a_ctrl_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_write |=> ctrl_q == $past(pwdata[PSS_CTL_W-1:0]))
    else $error("control write not stored");

  a_strb_ignore: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_acc && !pstrb[0] |=> $stable(ctrl_q) && $stable(evt_en_q))
    else $error("write without low strobe changed a register");

  a_enable_store: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_evt_write |=> evt_en_q == $past(pwdata[PSS_EVT_N-1:0]))
    else $error("event enable write not stored");

  a_rfault_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    remote_fault_seen |=> rf_q)
    else $error("remote fault not latched");

  a_flag_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(rd_acc && hit(paddr, PSS_IDX_EVENT)) |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("event flag lost without event status read");

  a_pin_test: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q[PSS_CTL_TEST] && irq_pin_n_oe) [*2] |-> !irq_pin_n_o)
    else $error("test interrupt not driven on pin");

  a_pd_masked: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_pin_n_oe |-> !powerdown_req)
    else $error("power-down request while pin is an output");

  // five edges cover three stages plus the agreement flop
  a_pd_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!irq_pin_n_oe && !irq_pin_n_i) [*5] |-> powerdown_req)
    else $error("low pin gave no power-down request");

  a_rfault_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    rf_q && !rd_basic_acc |=> rf_q)
    else $error("remote fault dropped without basic status read");

  a_rfault_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_basic_acc && !remote_fault_seen |=> !rf_q)
    else $error("remote fault not cleared by basic status read");

  a_sum_mirror: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_sum_setup |=> rdata_q[5:0] == $past({jabber_seen, an_complete, loopback_on,
                                          full_duplex, speed_10, link_up}))
    else $error("summary status bits do not mirror inputs");

  a_sum_pending: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_sum_setup |=> rdata_q[PSS_SUM_IRQ] == $past(irq_q))
    else $error("summary pending bit wrong");

  a_ctrl_rsvd: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_ph && !pwrite && hit(paddr, PSS_IDX_CTRL) |=> rdata_q[15:3] == 13'h0000)
    else $error("reserved control bits not zero");

  a_test_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[PSS_CTL_TEST] [*2] |-> irq_q)
    else $error("test interrupt not held");

  a_gate_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q[PSS_CTL_TEST] && !ctrl_q[PSS_CTL_EVT_IRQ_EN] |=> !irq_q)
    else $error("event interrupt raised with global enable off");

  a_irq_cause: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_q[PSS_CTL_EVT_IRQ_EN] && |(flag_q & evt_en_q) |=> irq_q)
    else $error("enabled pending event gave no interrupt");

  a_pin_role: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq_pin_n_oe == ctrl_q[PSS_CTL_OE] && (irq_pin_n_oe -> irq_pin_n_o == !irq_q))
    else $error("shared pin role or level wrong");

  a_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    |evt_pulse |=> (flag_q & $past(evt_pulse)) == $past(evt_pulse))
    else $error("event flag not set");

  a_read_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_evt_setup ##1 s_quiet_access |=> flag_q == PSS_EVT_RST ##1
      (!ctrl_q[PSS_CTL_TEST] -> !irq_q))
    else $error("event status read did not clear flags and interrupt");

  a_reset_zero: assert property (
    @(posedge pclk)
    $rose(presetn) |-> ctrl_q == PSS_CTRL_RST && flag_q == PSS_EVT_RST && !rf_q && !irq_q)
    else $error("state not zero after reset");

endmodule
`default_nettype wire

// File: verif/phy_status_and_irq_control_bench.sv
// self-checking bench for pss_top: status mirror, control, events, pin
// assumes pss_mgmt_model drives apb; reads are checked by a queue monitor
`timescale 1ns/1ps
`default_nettype none
module phy_status_and_irq_control_bench;
  import pss_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [PSS_AW-1:0] paddr;
  logic [PSS_DW-1:0] pwdata, prdata;
  logic [3:0]        pstrb;
  logic              link_up, speed_10, full_duplex, loopback_on, an_complete;
  logic              jabber_seen, remote_fault_seen, pd_drv_n, pin_n_w;
  logic              irq_pin_n_o, irq_pin_n_oe, powerdown_req;
  logic [7:0]        evt_pulse;
  logic [5:0]        v;
  logic [32:0]       exp_q[$];
  int                fail_count, n_compared;
  localparam int     PIN_OE  = 0;
  localparam int     PIN_OUT = 1;
  localparam int     PIN_PD  = 2;

  // pull-up idle; block drives only while its enable is high
  assign pin_n_w = irq_pin_n_oe ? irq_pin_n_o : pd_drv_n;

  pss_mgmt_model i_pss_mgmt_model (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready));

  pss_top i_pss_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link_up(link_up), .speed_10(speed_10),
    .full_duplex(full_duplex), .loopback_on(loopback_on), .an_complete(an_complete),
    .jabber_seen(jabber_seen), .remote_fault_seen(remote_fault_seen),
    .evt_pulse(evt_pulse), .irq_pin_n_i(pin_n_w), .irq_pin_n_o(irq_pin_n_o),
    .irq_pin_n_oe(irq_pin_n_oe), .powerdown_req(powerdown_req));

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [32:0] e, input logic [32:0] a);
    n_compared++;
    if (a !== e) begin
      fail_count++;
      $display("Error at %0t: read expected %h got %h", $time, e, a);
    end
  endtask

  // pins are looked at mid-cycle, after edge updates have landed;
  // a selector, so the value is read then and not when the call is made
  task automatic cmp_pin(input logic e, input int k);
    logic a;
    @(negedge pclk);
    if (k == PIN_OE) begin
      a = irq_pin_n_oe;
    end else if (k == PIN_OUT) begin
      a = irq_pin_n_o;
    end else begin
      a = powerdown_req;
    end
    n_compared++;
    if (a !== e) begin
      fail_count++;
      $display("Error at %0t: pin expected %h got %h", $time, e, a);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    i_pss_mgmt_model.xfer(w, {idx, 2'b00}, d, s);
    if (i_pss_mgmt_model.tmo === 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic rd(input logic [7:0] idx, input logic [15:0] e, input logic err);
    exp_q.push_back({err, 16'h0000, e});
    bus(1'b0, idx, 32'h0000_0000, 4'h0);
  endtask

  task automatic pulse(input logic [7:0] b);
    @(posedge pclk);
    evt_pulse <= b;
    @(posedge pclk);
    evt_pulse <= 8'h00;
    repeat (3) @(posedge pclk);
  endtask

  function automatic logic [15:0] sx(input logic rf, input logic irq);
    return {8'h00, irq, rf, v};
  endfunction

  // oldest note is matched against each completed read
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) begin
        cmp_rd(33'h1_ffff_ffff, {pslverr, prdata});
      end else begin
        cmp_rd(exp_q.pop_front(), {pslverr, prdata});
      end
    end
  end

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {link_up, speed_10, full_duplex, loopback_on, an_complete, jabber_seen} = 6'h00;
    remote_fault_seen = 1'b0;
    evt_pulse = 8'h00;
    pd_drv_n = 1'b1;
    v = 6'h00;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(32'hd592));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(PSS_IDX_SUMMARY, 16'h0000, 1'b0);
    rd(PSS_IDX_CTRL, 16'h0000, 1'b0);
    rd(PSS_IDX_EVENT, 16'h0000, 1'b0);
    cmp_pin(1'b0, PIN_OE);
    rd(8'h20, 16'h0000, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = 6'($urandom);
      // one pass with link up and negotiation settled
      if (i == 0) v = v | 6'h11;
      @(posedge pclk);
      {jabber_seen, an_complete, loopback_on, full_duplex, speed_10, link_up} <= v;
      rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
      rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    end
    $display("test status done");
    @(posedge pclk);
    remote_fault_seen <= 1'b1;
    @(posedge pclk);
    remote_fault_seen <= 1'b0;
    rd(PSS_IDX_SUMMARY, sx(1'b1, 1'b0), 1'b0);
    rd(PSS_IDX_SUMMARY, sx(1'b1, 1'b0), 1'b0);
    rd(PSS_IDX_BASIC, {10'h000, v[4], 1'b1, 1'b0, v[0], v[5], 1'b0}, 1'b0);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    $display("test remote fault done");
    bus(1'b1, PSS_IDX_CTRL, 32'hffff_ffff, 4'he);
    rd(PSS_IDX_CTRL, 16'h0000, 1'b0);
    bus(1'b1, PSS_IDX_CTRL, {16'($urandom), 16'hfffd}, 4'hf);
    rd(PSS_IDX_CTRL, 16'h0005, 1'b0);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b1), 1'b0);
    cmp_pin(1'b0, PIN_OUT);
    cmp_pin(1'b1, PIN_OE);
    bus(1'b1, PSS_IDX_CTRL, 32'h0000_0001, 4'hf);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    cmp_pin(1'b1, PIN_OUT);
    $display("test control done");
    bus(1'b1, PSS_IDX_EVENT, 32'h0000_0001, 4'hf);
    pulse(8'h02);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    rd(PSS_IDX_EVENT, 16'h0201, 1'b0);
    rd(PSS_IDX_EVENT, 16'h0001, 1'b0);
    pulse(8'h01);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    cmp_pin(1'b1, PIN_OUT);
    rd(PSS_IDX_EVENT, 16'h0101, 1'b0);
    bus(1'b1, PSS_IDX_CTRL, 32'h0000_0003, 4'hf);
    pulse(8'h01);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b1), 1'b0);
    cmp_pin(1'b0, PIN_OUT);
    rd(PSS_IDX_EVENT, 16'h0101, 1'b0);
    rd(PSS_IDX_SUMMARY, sx(1'b0, 1'b0), 1'b0);
    cmp_pin(1'b1, PIN_OUT);
    $display("test events done");
    bus(1'b1, PSS_IDX_CTRL, 32'h0000_0000, 4'hf);
    @(posedge pclk);
    pd_drv_n <= 1'b0;
    repeat (6) @(posedge pclk);
    cmp_pin(1'b1, PIN_PD);
    cmp_pin(1'b0, PIN_OE);
    @(posedge pclk);
    pd_drv_n <= 1'b1;
    repeat (6) @(posedge pclk);
    cmp_pin(1'b0, PIN_PD);
    $display("test pin input done");
    @(negedge pclk);
    if (exp_q.size() != 0) fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

// File: verif/pss_mgmt_model.sv
// apb master standing in for the station management side
// assumes a pclk slave; waits for pready under a bounded count
`timescale 1ns/1ps
`default_nettype none
module pss_mgmt_model
  import pss_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb master
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic [PSS_AW-1:0]      paddr,
  output logic [PSS_DW-1:0]      pwdata,
  output logic [3:0]             pstrb,
  input  wire logic              pready
);
  logic tmo;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'h0;
    tmo     = 1'b0;
  end

  // request held unchanged until pready is seen high at an edge
  task automatic xfer(input logic w, input logic [PSS_AW-1:0] a,
                      input logic [PSS_DW-1:0] d, input logic [3:0] s);
    int n;
    int r;
    n = 0;
    r = 0;
    while (presetn !== 1'b1 && r < 64) begin
      @(posedge pclk);
      r++;
    end
    if (r >= 64) tmo = 1'b1;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) tmo = 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire
